// >>> avrp_pkg.sv
`default_nettype none

package avrp_pkg;

   // ------------------------------------------------------------------
   // register map and reset values
   // ------------------------------------------------------------------
   localparam logic [7:0] ADDR_PAIR_B_CTRL = 8'h1e;
   localparam logic [7:0] ADDR_CH0_VOL     = 8'h1f;
   localparam logic [7:0] ADDR_CH1_VOL     = 8'h20;
   localparam logic [7:0] ADDR_CH2_VOL     = 8'h21;
   localparam logic [7:0] ADDR_CH3_VOL     = 8'h22;
   localparam logic [7:0] RST_PAIR_B_CTRL  = 8'h00;
   localparam logic [7:0] RST_VOL          = 8'h00;
   localparam logic [7:0] READ_UNMAPPED    = 8'h00;

   // ------------------------------------------------------------------
   // field encodings
   // ------------------------------------------------------------------
   localparam logic [1:0] HP_OFF    = 2'h0;
   localparam logic [1:0] HP_1HZ    = 2'h1;
   localparam logic [1:0] HP_4HZ    = 2'h2;
   localparam logic [1:0] HP_8HZ    = 2'h3;
   localparam logic [1:0] RATE_96K  = 2'h0;
   localparam logic [1:0] RATE_192K = 2'h1;

   // ------------------------------------------------------------------
   // volume scale and ramp timing
   // ------------------------------------------------------------------
   localparam logic [7:0] VOL_ZERO_DB    = 8'h00;
   localparam logic [7:0] VOL_FULL_ATTEN = 8'hff;
   localparam logic [3:0] RAMP_TICK_LAST = 4'hf;    // 16 sample periods per step

   localparam int unsigned CLK_HZ      = 125_000_000;
   localparam int unsigned FS_96K_HZ   = 96_000;
   localparam int unsigned FS_192K_HZ  = 192_000;
   localparam int unsigned DIV_96K     = CLK_HZ / FS_96K_HZ;
   localparam int unsigned DIV_192K    = CLK_HZ / FS_192K_HZ;
   localparam logic [10:0] DIV_96K_LAST  = 11'(DIV_96K - 1);
   localparam logic [10:0] DIV_192K_LAST = 11'(DIV_192K - 1);
   localparam logic [10:0] DIV_ZERO      = 11'h000;

   // ------------------------------------------------------------------
   // types
   // ------------------------------------------------------------------
   typedef struct packed {
      logic       reserved7;
      logic [1:0] highpass_corner_sel_b;
      logic       mic_bit_polarity_b;
      logic       mic_lr_exchange_b;
      logic       decimator_source_sel_b;
      logic       chan3_enable;
      logic       chan2_enable;
   } avrp_ctrl_t;

   typedef struct packed {
      logic [7:0] addr;
      logic       wr_en;
      logic       rd_en;
      logic [7:0] wdata;
   } avrp_reg_req_t;

   typedef enum logic [2:0] {
      RAMP_OFF  = 3'b001,
      RAMP_RUN  = 3'b010,
      RAMP_HOLD = 3'b100
   } avrp_ramp_state_t;

endpackage

`default_nettype wire

// >>> avrp_vol_ramp.sv
`timescale 1ns/1ps
`default_nettype none

module avrp_vol_ramp (
   // clock and reset
   input  wire logic       core_clk,
   input  wire logic       srst,
   // control
   input  wire logic       sync_en,
   input  wire logic       sample_tick,
   input  wire logic [7:0] target,
   // current attenuation code
   output logic      [7:0] level_r
);
   import avrp_pkg::*;

   avrp_ramp_state_t state_r;
   avrp_ramp_state_t state_nxt;
   logic       [7:0] level_nxt;
   logic       [3:0] tick_cnt_r;
   logic       [3:0] tick_cnt_nxt;

   // ------------------------------------------------------------------
   // ramp sequencer
   // ------------------------------------------------------------------
   always_comb begin
      state_nxt    = state_r;
      level_nxt    = level_r;
      tick_cnt_nxt = tick_cnt_r;
      unique case (state_r)
         RAMP_OFF: begin
            level_nxt    = VOL_FULL_ATTEN;
            tick_cnt_nxt = 4'h0;
            if (sync_en) begin
               state_nxt = RAMP_RUN;
            end
         end
         RAMP_RUN, RAMP_HOLD: begin
            if (!sync_en) begin
               state_nxt    = RAMP_OFF;
               level_nxt    = VOL_FULL_ATTEN;
               tick_cnt_nxt = 4'h0;
            end else if (sample_tick) begin
               tick_cnt_nxt = tick_cnt_r + 4'h1;
               if (tick_cnt_r == RAMP_TICK_LAST) begin
                  // one code per step, so the target is met exactly
                  if (level_r > target) begin
                     level_nxt = level_r - 8'h01;
                  end else if (level_r < target) begin
                     level_nxt = level_r + 8'h01;
                  end
               end
               state_nxt = (level_nxt == target) ? RAMP_HOLD : RAMP_RUN;
            end
         end
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         state_r    <= RAMP_OFF;
         level_r    <= VOL_FULL_ATTEN;
         tick_cnt_r <= 4'h0;
      end else begin
         state_r    <= state_nxt;
         level_r    <= level_nxt;
         tick_cnt_r <= tick_cnt_nxt;
      end
   end

   // ------------------------------------------------------------------
   // checks
   // ------------------------------------------------------------------
   chk_ramp_start_full: assert property (@(posedge core_clk) disable iff (srst)
      (state_r == RAMP_OFF && sync_en) |=> (level_r == VOL_FULL_ATTEN && state_r != RAMP_OFF))
      else $error("ramp did not start at full attenuation");

   chk_ramp_step_rate: assert property (@(posedge core_clk) disable iff (srst)
      (state_r != RAMP_OFF && sync_en && !(sample_tick && tick_cnt_r == RAMP_TICK_LAST))
      |=> $stable(level_r))
      else $error("volume moved between step boundaries");

   chk_ramp_no_overshoot: assert property (@(posedge core_clk) disable iff (srst)
      (state_r != RAMP_OFF && sync_en && level_r > target && $stable(target))
      |=> (level_r >= $past(target) && (level_r == $past(level_r)
          || level_r == $past(level_r) - 8'h01)))
      else $error("ramp overshot or jumped more than one code");

   cov_ramp_settles: cover property (@(posedge core_clk) disable iff (srst)
      state_r == RAMP_RUN ##1 state_r == RAMP_HOLD);

endmodule

`default_nettype wire

// >>> avrp_adc_path_regs.sv
`timescale 1ns/1ps
`default_nettype none


module avrp_adc_path_regs (
   // clock and reset
   input  wire logic                  core_clk,
   input  wire logic                  srst,
   // register port
   input  wire avrp_pkg::avrp_reg_req_t reg_req,
   output logic       [7:0]           reg_rdata_r,
   // companion control bits held elsewhere
   input  wire logic  [3:0]           sync_en,
   input  wire logic  [1:0]           chan_enable_a,
   input  wire logic                  channel2_silence,
   input  wire logic                  channel3_silence,
   input  wire logic  [3:0]           vol_bypass,
   input  wire logic  [1:0]           pair_b_rate_sel,
   input  wire logic                  fs_tick_a,
   // sample inputs
   input  wire logic                  mic_clk,
   input  wire logic                  mic_data,
   input  wire logic  [1:0]           mod_bit,
   // path controls
   output logic       [1:0]           highpass_corner_sel_b,
   output logic                       hp_bypass_r,
   output logic                       decimator_source_sel_b,
   output logic       [3:0]           chan_active_r,
   output logic       [3:0][7:0]      attenuation_r,
   output logic       [1:0]           decim_bit_r,
   output logic                       tick_b_r
);
   import avrp_pkg::*;

   avrp_ctrl_t       ctrl_r;
   avrp_ctrl_t       ctrl_nxt;
   logic [3:0][7:0]  vol_r;
   logic [3:0][7:0]  vol_nxt;
   logic [7:0]       rdata_nxt;
   logic [3:0][7:0]  ramp_level;
   logic [3:0][7:0]  atten_nxt;
   logic [3:0]       ramp_tick;
   logic [3:0]       mute;
   logic [3:0]       active_nxt;
   logic             hp_bypass_nxt;
   logic [10:0]      div_cnt_r;
   logic [10:0]      div_cnt_nxt;
   logic [10:0]      div_last;
   logic             tick_b_nxt;
   logic             mic_clk_d_r;
   logic             mic_rise;
   logic             mic_fall;
   logic [1:0]       mic_sign_r;
   logic [1:0]       mic_sign_nxt;
   logic [1:0]       decim_nxt;

   // ------------------------------------------------------------------
   // register file
   // ------------------------------------------------------------------
   always_comb begin
      ctrl_nxt  = ctrl_r;
      vol_nxt   = vol_r;
      rdata_nxt = reg_rdata_r;
      if (reg_req.wr_en) begin
         unique case (reg_req.addr)
            ADDR_PAIR_B_CTRL: ctrl_nxt   = avrp_ctrl_t'(reg_req.wdata);
            ADDR_CH0_VOL:     vol_nxt[0] = reg_req.wdata;
            ADDR_CH1_VOL:     vol_nxt[1] = reg_req.wdata;
            ADDR_CH2_VOL:     vol_nxt[2] = reg_req.wdata;
            ADDR_CH3_VOL:     vol_nxt[3] = reg_req.wdata;
            default: begin
            end
         endcase
      end
      if (reg_req.rd_en) begin
         unique case (reg_req.addr)
            ADDR_PAIR_B_CTRL: rdata_nxt = ctrl_r;
            ADDR_CH0_VOL:     rdata_nxt = vol_r[0];
            ADDR_CH1_VOL:     rdata_nxt = vol_r[1];
            ADDR_CH2_VOL:     rdata_nxt = vol_r[2];
            ADDR_CH3_VOL:     rdata_nxt = vol_r[3];
            default:          rdata_nxt = READ_UNMAPPED;
         endcase
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         ctrl_r      <= avrp_ctrl_t'(RST_PAIR_B_CTRL);
         vol_r       <= {4{RST_VOL}};
         reg_rdata_r <= READ_UNMAPPED;
      end else begin
         ctrl_r      <= ctrl_nxt;
         vol_r       <= vol_nxt;
         reg_rdata_r <= rdata_nxt;
      end
   end

   // the reserved bit is stored for read-back only and steers nothing
   assign highpass_corner_sel_b  = ctrl_r.highpass_corner_sel_b;
   assign decimator_source_sel_b = ctrl_r.decimator_source_sel_b;

   // ------------------------------------------------------------------
   // sample clock for the second pair
   // ------------------------------------------------------------------
   // reserved rate codes stop the tick, so those channels freeze
   always_comb begin
      div_last    = (pair_b_rate_sel == RATE_96K) ? DIV_96K_LAST : DIV_192K_LAST;
      div_cnt_nxt = DIV_ZERO;
      tick_b_nxt  = 1'b0;
      if (pair_b_rate_sel == RATE_96K || pair_b_rate_sel == RATE_192K) begin
         if (div_cnt_r >= div_last) begin
            tick_b_nxt = 1'b1;
         end else begin
            div_cnt_nxt = div_cnt_r + 11'h001;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         div_cnt_r <= DIV_ZERO;
         tick_b_r  <= 1'b0;
      end else begin
         div_cnt_r <= div_cnt_nxt;
         tick_b_r  <= tick_b_nxt;
      end
   end

   // ------------------------------------------------------------------
   // digital microphone capture and decimator feed
   // ------------------------------------------------------------------
   assign mic_rise = mic_clk && !mic_clk_d_r;
   assign mic_fall = !mic_clk && mic_clk_d_r;

   always_comb begin
      mic_sign_nxt = mic_sign_r;
      // sign flag: 1 means the bit reads as negative
      if (mic_rise) begin
         mic_sign_nxt[ctrl_r.mic_lr_exchange_b] =
            mic_data ^ ctrl_r.mic_bit_polarity_b;
      end
      if (mic_fall) begin
         mic_sign_nxt[!ctrl_r.mic_lr_exchange_b] =
            mic_data ^ ctrl_r.mic_bit_polarity_b;
      end
      decim_nxt     = ctrl_r.decimator_source_sel_b ? mic_sign_nxt : mod_bit;
      hp_bypass_nxt = (ctrl_r.highpass_corner_sel_b == HP_OFF);
      active_nxt    = {ctrl_r.chan3_enable, ctrl_r.chan2_enable, chan_enable_a}
                      & sync_en;
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         mic_clk_d_r   <= 1'b0;
         mic_sign_r    <= 2'b00;
         decim_bit_r   <= 2'b00;
         hp_bypass_r   <= 1'b1;
         chan_active_r <= 4'h0;
      end else begin
         mic_clk_d_r   <= mic_clk;
         mic_sign_r    <= mic_sign_nxt;
         decim_bit_r   <= decim_nxt;
         hp_bypass_r   <= hp_bypass_nxt;
         chan_active_r <= active_nxt;
      end
   end

   // ------------------------------------------------------------------
   // per-channel volume ramp, and mute on channels 2 and 3 only
   // ------------------------------------------------------------------
   assign mute = {channel3_silence, channel2_silence, 2'b00};

   generate
      for (genvar ch = 0; ch < 4; ch++) begin : g_chan
         assign ramp_tick[ch] = (ch < 2) ? fs_tick_a : tick_b_r;

         avrp_vol_ramp u_ramp (
            .core_clk    (core_clk),
            .srst        (srst),
            .sync_en     (sync_en[ch]),
            .sample_tick (ramp_tick[ch]),
            .target      (vol_r[ch]),
            .level_r     (ramp_level[ch])
         );

         // bypass means unity gain, so mute cannot act there
         always_comb begin
            if (vol_bypass[ch]) begin
               atten_nxt[ch] = VOL_ZERO_DB;
            end else if (mute[ch]) begin
               atten_nxt[ch] = VOL_FULL_ATTEN;
            end else begin
               atten_nxt[ch] = ramp_level[ch];
            end
         end

         always_ff @(posedge core_clk) begin
            if (srst) begin
               attenuation_r[ch] <= VOL_FULL_ATTEN;
            end else begin
               attenuation_r[ch] <= atten_nxt[ch];
            end
         end
      end
   endgenerate

   // ------------------------------------------------------------------
   // checks
   // ------------------------------------------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (srst);

   chk_hp_bypass_code: assert property (
      ##1 hp_bypass_r == ($past(ctrl_r.highpass_corner_sel_b) == HP_OFF))
      else $error("highpass bypass flag does not follow the field");

   chk_mic_polarity: assert property (
      (mic_rise && !mic_fall && !ctrl_r.mic_lr_exchange_b)
      |=> mic_sign_r[0] == ($past(mic_data) ^ $past(ctrl_r.mic_bit_polarity_b)))
      else $error("mic polarity applied wrongly");

   chk_mic_swap_edge: assert property (
      (mic_fall && ctrl_r.mic_lr_exchange_b) |=> $stable(mic_sign_r[1]))
      else $error("swapped falling edge wrote the left channel");

   chk_decim_source: assert property (
      !ctrl_r.decimator_source_sel_b |=> decim_bit_r == $past(mod_bit))
      else $error("modulator source not routed to decimators");

   chk_chan_active: assert property (
      (!sync_en[2]) |=> !chan_active_r[2])
      else $error("channel active without its sync enable");

   chk_vol_store: assert property (
      (reg_req.wr_en && reg_req.addr == ADDR_CH1_VOL) |=> vol_r[1] == $past(reg_req.wdata))
      else $error("volume write not stored");

   chk_mute_full: assert property (
      (channel3_silence && !vol_bypass[3]) |=> attenuation_r[3] == VOL_FULL_ATTEN)
      else $error("muted channel not at full attenuation");

   chk_rate_reserved: assert property (
      (pair_b_rate_sel[1] && $past(pair_b_rate_sel[1])) |-> !tick_b_r)
      else $error("reserved rate code produced a sample tick");

   chk_reserved_readback: assert property (
      (reg_req.rd_en && reg_req.addr == ADDR_PAIR_B_CTRL)
      |=> reg_rdata_r[7] == $past(ctrl_r.reserved7))
      else $error("reserved bit does not read back");

   cov_ctrl_write: cover property (reg_req.wr_en && reg_req.addr == ADDR_PAIR_B_CTRL);
   cov_mic_swapped: cover property (mic_rise && ctrl_r.mic_lr_exchange_b);
   cov_rate_tick: cover property (tick_b_r && pair_b_rate_sel == RATE_192K);

endmodule

`default_nettype wire

// >>> tb_adc_path_config_volume_ramp.sv
`timescale 1ns/1ps
`default_nettype none

module tb_adc_path_config_volume_ramp;
   import avrp_pkg::*;

   // ------------------------------------------------------------------
   // signals and instance
   // ------------------------------------------------------------------
   logic                core_clk = 1'b0;
   logic                srst     = 1'b1;
   avrp_reg_req_t       reg_req  = '0;
   logic [7:0]          reg_rdata_r;
   logic [3:0]          sync_en = 4'h0;
   logic [1:0]          chan_enable_a = 2'h0;
   logic                channel2_silence = 1'b0;
   logic                channel3_silence = 1'b0;
   logic [3:0]          vol_bypass = 4'h0;
   logic [1:0]          pair_b_rate_sel = 2'h0;
   logic                fs_tick_a = 1'b0;
   logic                mic_clk = 1'b0;
   logic                mic_data = 1'b0;
   logic [1:0]          mod_bit = 2'h0;
   logic [1:0]          highpass_corner_sel_b;
   logic                hp_bypass_r;
   logic                decimator_source_sel_b;
   logic [3:0]          chan_active_r;
   logic [3:0][7:0]     attenuation_r;
   logic [1:0]          decim_bit_r;
   logic                tick_b_r;
   int                  err_total = 0;
   int                  n_checks = 0;

   avrp_adc_path_regs dut (
      .core_clk(core_clk), .srst(srst), .reg_req(reg_req), .reg_rdata_r(reg_rdata_r),
      .sync_en(sync_en), .chan_enable_a(chan_enable_a),
      .channel2_silence(channel2_silence), .channel3_silence(channel3_silence),
      .vol_bypass(vol_bypass), .pair_b_rate_sel(pair_b_rate_sel), .fs_tick_a(fs_tick_a),
      .mic_clk(mic_clk), .mic_data(mic_data), .mod_bit(mod_bit),
      .highpass_corner_sel_b(highpass_corner_sel_b), .hp_bypass_r(hp_bypass_r),
      .decimator_source_sel_b(decimator_source_sel_b), .chan_active_r(chan_active_r),
      .attenuation_r(attenuation_r), .decim_bit_r(decim_bit_r), .tick_b_r(tick_b_r)
   );

   always #4 core_clk = ~core_clk;

   // ------------------------------------------------------------------
   // shared tasks
   // ------------------------------------------------------------------
   task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string msg);
      n_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("[FAIL] %0t %s: seen %h expected %h", $time, msg, seen, exp);
      end
   endtask

   // inputs always move 1 ns after the rising edge
   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask

   task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
      cyc(1);
      reg_req.addr  = a;
      reg_req.wdata = d;
      reg_req.wr_en = 1'b1;
      cyc(1);
      reg_req.wr_en = 1'b0;
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input string msg);
      cyc(1);
      reg_req.addr  = a;
      reg_req.rd_en = 1'b1;
      cyc(1);
      reg_req.rd_en = 1'b0;
      check(reg_rdata_r, exp, msg);
   endtask

   task automatic pulse_a(input int n);
      repeat (n) begin
         fs_tick_a = 1'b1;
         cyc(1);
         fs_tick_a = 1'b0;
         cyc(1);
      end
   endtask

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // ------------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------------
   task automatic t_regs();
      for (int i = 0; i < 5; i++) begin
         rd_chk(ADDR_PAIR_B_CTRL + 8'(i), 8'h00, "reset value");
         reg_wr(ADDR_PAIR_B_CTRL + 8'(i), 8'h81 + 8'(i * 8'h11));
      end
      reg_wr(8'h23, 8'hff);
      reg_wr(8'h1d, 8'hff);
      for (int i = 0; i < 5; i++) begin
         rd_chk(ADDR_PAIR_B_CTRL + 8'(i), 8'h81 + 8'(i * 8'h11), "rb");
      end
      rd_chk(8'h23, 8'h00, "unmapped read");
      reg_wr(ADDR_PAIR_B_CTRL, 8'h80);
      rd_chk(ADDR_PAIR_B_CTRL, 8'h80, "reserved bit");
      $display("test regs done");
   endtask

   task automatic t_fields();
      for (int h = 0; h < 4; h++) begin
         reg_wr(ADDR_PAIR_B_CTRL, {1'b1, 2'(h), 5'b00100});
         cyc(2);
         check(8'(highpass_corner_sel_b), 8'(h), "highpass");
         check(8'(hp_bypass_r), 8'(h == 0), "hp bypass");
         check(8'(decimator_source_sel_b), 8'h01, "source");
      end
      $display("test fields done");
   endtask

   task automatic t_enable();
      logic [3:0] e [4] = '{4'hf, 4'hf, 4'h0, 4'h5};
      logic [3:0] s [4] = '{4'hf, 4'h0, 4'hf, 4'h3};
      for (int i = 0; i < 4; i++) begin
         chan_enable_a = e[i][1:0];
         sync_en       = s[i];
         reg_wr(ADDR_PAIR_B_CTRL, {6'h20, e[i][3:2]});
         cyc(3);
         check(8'(chan_active_r), 8'(e[i] & s[i]), "channel active");
      end
      sync_en = 4'h0;
      chan_enable_a = 2'h0;
      $display("test enable done");
   endtask

   task automatic t_mic();
      logic p;
      logic s;
      logic d;
      for (int c = 0; c < 8; c++) begin
         {p, s, d} = 3'(c);
         reg_wr(ADDR_PAIR_B_CTRL, {3'b000, p, s, 3'b100});
         mic_data = d;
         cyc(1);
         mic_clk = 1'b1;
         cyc(3);
         check(8'(decim_bit_r[s]), 8'(d ^ p), "mic rising");
         mic_data = ~d;
         cyc(1);
         mic_clk = 1'b0;
         cyc(3);
         check(8'(decim_bit_r[~s]), 8'(d ^ p ^ 1'b1), "mic falling");
      end
      reg_wr(ADDR_PAIR_B_CTRL, 8'h10);
      check(8'(decimator_source_sel_b), 8'h00, "source adc");
      for (int m = 1; m < 4; m++) begin
         mod_bit = 2'(m);
         cyc(3);
         check(8'(decim_bit_r), 8'(m), "modulator path");
      end
      $display("test mic done");
   endtask

   task automatic t_ramp_a();
      reg_wr(ADDR_CH0_VOL, 8'hfd);
      sync_en[0] = 1'b1;
      cyc(3);
      check(attenuation_r[0], VOL_FULL_ATTEN, "ramp start");
      pulse_a(15);
      cyc(2);
      check(attenuation_r[0], 8'hff, "before 16th tick");
      pulse_a(1);
      cyc(2);
      check(attenuation_r[0], 8'hfe, "first step");
      pulse_a(16);
      cyc(2);
      check(attenuation_r[0], 8'hfd, "second step");
      pulse_a(16);
      cyc(2);
      check(attenuation_r[0], 8'hfd, "no overshoot");
      reg_wr(ADDR_CH0_VOL, 8'hfe);
      pulse_a(16);
      cyc(2);
      check(attenuation_r[0], 8'hfe, "retarget");
      sync_en[0] = 1'b0;
      cyc(3);
      check(attenuation_r[0], 8'hff, "sync off");
      $display("test ramp a done");
   endtask

   task automatic tick_gap(output int n);
      int k;
      k = 0;
      while (tick_b_r !== 1'b1 && k < 3000) begin
         cyc(1);
         k++;
      end
      cyc(1);
      n = 1;
      while (tick_b_r !== 1'b1 && n < 3000) begin
         cyc(1);
         n++;
      end
   endtask

   task automatic t_pair_b();
      int n;
      pair_b_rate_sel = RATE_192K;
      tick_gap(n);
      check(8'(n == DIV_192K), 8'h01, "192k period");
      pair_b_rate_sel = RATE_96K;
      tick_gap(n);
      tick_gap(n);
      check(8'(n == DIV_96K), 8'h01, "96k period");
      pair_b_rate_sel = 2'h2;
      cyc(2);
      n = 0;
      repeat (3000) begin
         cyc(1);
         n += int'(tick_b_r === 1'b1);
      end
      check(8'(n), 8'h00, "reserved rate");
      pair_b_rate_sel = RATE_192K;
      reg_wr(ADDR_CH2_VOL, 8'h00);
      sync_en[2] = 1'b1;
      cyc(3);
      check(attenuation_r[2], 8'hff, "pair b start");
      n = 0;
      while (attenuation_r[2] === 8'hff && n < 17 * DIV_192K) begin
         cyc(1);
         n++;
      end
      check(8'(n > 15 * DIV_192K), 8'h01, "pair b step time");
      check(attenuation_r[2], 8'hfe, "pair b step");
      channel2_silence = 1'b1;
      cyc(3);
      check(attenuation_r[2], 8'hff, "mute");
      vol_bypass = 4'hc;
      channel3_silence = 1'b1;
      cyc(3);
      check(attenuation_r[2], 8'h00, "bypass wins");
      check(attenuation_r[3], 8'h00, "bypass wins");
      vol_bypass = 4'h0;
      channel2_silence = 1'b0;
      cyc(3);
      check(attenuation_r[2], 8'hfe, "unmute");
      $display("test pair b done");
   endtask

   // ------------------------------------------------------------------
   // main sequence and watchdog
   // ------------------------------------------------------------------
   initial begin
      cyc(12);
      srst = 1'b0;
      for (int i = 0; i < 4; i++) begin
         check(attenuation_r[i], 8'hff, "reset attenuation");
      end
      check(8'(hp_bypass_r), 8'h01, "reset bypass");
      t_regs();
      t_fields();
      t_enable();
      t_mic();
      t_ramp_a();
      t_pair_b();
      print_verdict();
   end

   initial begin
      repeat (40000) @(posedge core_clk);
      err_total++;
      print_verdict();
   end

endmodule

`default_nettype wire
